/* ldfsr_top.sv */
// Purpose: diagnostic and fault status register bank of a two-channel amplifier
// Assumes: control interface decodes to byte reads and writes on mclk
// Notes:   read data is registered one cycle after the read strobe
//
// Contract
// - per-channel 4-bit shorted-load threshold, ch1 bits 7-4, ch2 bits 3-0, reset 0001
// - short-to-ground flag per channel at bits 7 and 3 of report one
// - short-to-supply flag per channel at bits 6 and 2 of report one
// - open-load flag per channel at bits 5 and 1 of report one
// - shorted-load flag per channel at bits 4 and 0 of report one
// - line-output found at bits 3 and 2, other bits zero
// - 2-bit state per channel, bits 7-6 and 5-4, reserved pairs read 01
// - overcurrent flags at bits 7 and 6 of channel fault register
// - dc offset flags at bits 3 and 2 of channel fault register
// - invalid clock flag at global fault bit 4, reset zero
// - power stage overvoltage at global fault bit 3
// - battery overvoltage at global fault bit 2
// - power stage undervoltage at global fault bit 1
// - battery undervoltage at global fault bit 0, upper bits zero
// - requested channel state comes from writable state control register
// - auto diagnostics on leaving high impedance and on fault unless skipped
// - line output detection updates only when enabled

`timescale 1ns/100ps

module ldfsr_top
  import ldfsr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [1:0]  diag_done,
  input  wire logic [3:0]  first_chan_diag_result,
  input  wire logic [3:0]  second_chan_diag_result,
  input  wire logic [1:0]  line_out_seen,
  input  wire logic [1:0]  overcurrent_lvl,
  input  wire logic [1:0]  dc_offset_lvl,
  input  wire logic        invalid_clock_lvl,
  input  wire logic        power_stage_overvoltage_lvl,
  input  wire logic        battery_overvoltage_lvl,
  input  wire logic        power_stage_undervoltage_lvl,
  input  wire logic        battery_undervoltage_lvl,
  output logic      [1:0]  diag_start,
  output logic      [3:0]  first_chan_short_threshold,
  output logic      [3:0]  second_chan_short_threshold,
  output logic      [1:0]  first_chan_state,
  output logic      [1:0]  second_chan_state
);

  localparam int FW = 9;

  typedef struct packed {
    logic [7:0] state_ctrl;
    logic [7:0] diag_ctrl;
    logic [7:0] thresh;
    logic [7:0] rdata;
  } ldfsr_top_st_t;

  ldfsr_top_st_t st_reg;
  ldfsr_top_st_t st_next;

  logic [3:0]    res1;
  logic [3:0]    res2;
  logic [1:0]    lo_found;
  logic [FW-1:0] fault_lvl;
  logic [FW-1:0] fault_flags;
  logic [7:0]    diag_res_val;
  logic [7:0]    lo_res_val;
  logic [7:0]    state_rb_val;
  logic [7:0]    ch_fault_val;
  logic [7:0]    glb_fault_val;
  logic [1:0]    chan_fault;
  logic          auto_diag_skip;
  logic          line_out_diag_enable;

  // ==========================================================
  // address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign auto_diag_skip       = st_reg.diag_ctrl[SKIP_BIT];
  assign line_out_diag_enable = st_reg.diag_ctrl[LO_EN_BIT];

  // ==========================================================
  // channel trackers
  assign chan_fault = overcurrent_lvl | dc_offset_lvl;

  ldfsr_chan u_ch1 (
    .mclk                 (mclk),
    .reset_n              (reset_n),
    .req_state            (st_reg.state_ctrl[ST1_HI:ST1_LO]),
    .auto_diag_skip       (auto_diag_skip),
    .line_out_diag_enable (line_out_diag_enable),
    .chan_fault           (chan_fault[1]),
    .diag_done            (diag_done[0]),
    .diag_result          (first_chan_diag_result),
    .line_out_seen        (line_out_seen[1]),
    .diag_start           (diag_start[0]),
    .state_readback       (first_chan_state),
    .result_flags         (res1),
    .line_out_found       (lo_found[1])
  );

  ldfsr_chan u_ch2 (
    .mclk                 (mclk),
    .reset_n              (reset_n),
    .req_state            (st_reg.state_ctrl[ST2_HI:ST2_LO]),
    .auto_diag_skip       (auto_diag_skip),
    .line_out_diag_enable (line_out_diag_enable),
    .chan_fault           (chan_fault[0]),
    .diag_done            (diag_done[1]),
    .diag_result          (second_chan_diag_result),
    .line_out_seen        (line_out_seen[0]),
    .diag_start           (diag_start[1]),
    .state_readback       (second_chan_state),
    .result_flags         (res2),
    .line_out_found       (lo_found[0])
  );

  // ==========================================================
  // fault capture
  assign fault_lvl = {overcurrent_lvl,
                      dc_offset_lvl,
                      invalid_clock_lvl,
                      power_stage_overvoltage_lvl,
                      battery_overvoltage_lvl,
                      power_stage_undervoltage_lvl,
                      battery_undervoltage_lvl};

  ldfsr_fault #(
    .W (FW)
  ) u_fault (
    .mclk        (mclk),
    .reset_n     (reset_n),
    .fault_lvl   (fault_lvl),
    .fault_flags (fault_flags)
  );

  // ==========================================================
  // read-only images
  assign diag_res_val  = {res1, res2};
  assign lo_res_val    = {4'h0, lo_found, 2'h0};
  assign state_rb_val  = {first_chan_state, second_chan_state, STATE_RSVD};
  assign ch_fault_val  = {fault_flags[8:7], 2'h0, fault_flags[6:5], 2'h0};
  assign glb_fault_val = {3'h0, fault_flags[4:0]};

  // ==========================================================
  // register access
  always_comb begin
    st_next = st_reg;
    if (reg_wr) begin
      if (hit(reg_addr, ADDR_STATE_CTRL)) begin
        st_next.state_ctrl = reg_wdata;
      end
      if (hit(reg_addr, ADDR_DIAG_CTRL)) begin
        st_next.diag_ctrl = reg_wdata;
      end
      if (hit(reg_addr, ADDR_THRESH)) begin
        st_next.thresh = reg_wdata;
      end
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_STATE_CTRL: st_next.rdata = st_reg.state_ctrl;
        ADDR_DIAG_CTRL:  st_next.rdata = st_reg.diag_ctrl;
        ADDR_THRESH:     st_next.rdata = st_reg.thresh;
        ADDR_DIAG_RES:   st_next.rdata = diag_res_val;
        ADDR_LO_RES:     st_next.rdata = lo_res_val;
        ADDR_STATE_RB:   st_next.rdata = state_rb_val;
        ADDR_CH_FAULT:   st_next.rdata = ch_fault_val;
        ADDR_GLB_FAULT:  st_next.rdata = glb_fault_val;
        default:         st_next.rdata = RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_reg.state_ctrl <= RST_STATE_CTRL;
      st_reg.diag_ctrl  <= RST_DIAG_CTRL;
      st_reg.thresh     <= RST_THRESH;
      st_reg.rdata      <= RST_ZERO;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata                   = st_reg.rdata;
  assign first_chan_short_threshold  = st_reg.thresh[CH1_HI:CH1_LO];
  assign second_chan_short_threshold = st_reg.thresh[CH2_HI:CH2_LO];

  // ==========================================================
  // checks
  sequence s_rd(logic [7:0] off);
    reg_rd && reg_addr == off;
  endsequence

  sequence s_wr(logic [7:0] off);
    reg_wr && reg_addr == off;
  endsequence

  property p_thr_write;
    @(posedge mclk) disable iff (!reset_n)
      reg_wr && reg_addr == ADDR_THRESH
      |=> {first_chan_short_threshold, second_chan_short_threshold} == $past(reg_wdata);
  endproperty
  a_thr_write: assert property (p_thr_write)
    else $error("threshold write not stored");

  property p_ro_write;
    @(posedge mclk) disable iff (!reset_n)
      reg_wr && reg_addr == ADDR_DIAG_RES && diag_done == 2'h0 |=> $stable(diag_res_val);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write changed a read-only report");

  property p_glb_read;
    @(posedge mclk) disable iff (!reset_n)
      s_rd(ADDR_GLB_FAULT) |=> reg_rdata == {3'h0, $past(fault_flags[4:0])};
  endproperty
  a_glb_read: assert property (p_glb_read)
    else $error("global fault read mismatch");

  property p_lo_read;
    @(posedge mclk) disable iff (!reset_n)
      s_rd(ADDR_LO_RES) |=> reg_rdata[7:4] == 4'h0 && reg_rdata[1:0] == 2'h0;
  endproperty
  a_lo_read: assert property (p_lo_read)
    else $error("line output reserved bits nonzero");

  property p_rb_read;
    @(posedge mclk) disable iff (!reset_n)
      s_rd(ADDR_STATE_RB) |=> reg_rdata[3:0] == STATE_RSVD
                              && reg_rdata[7:6] == $past(first_chan_state);
  endproperty
  a_rb_read: assert property (p_rb_read)
    else $error("state readback mismatch");

  property p_reset_flags;
    @(posedge mclk)
      !$past(reset_n) |-> diag_res_val == RST_ZERO && glb_fault_val == RST_ZERO;
  endproperty
  a_reset_flags: assert property (p_reset_flags)
    else $error("flags not cleared by reset");

  property p_oc_flags;
    @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> ch_fault_val[7:6] == $past(overcurrent_lvl);
  endproperty
  a_oc_flags: assert property (p_oc_flags)
    else $error("overcurrent flags do not follow detectors");

  property p_dc_flags;
    @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> ch_fault_val[3:2] == $past(dc_offset_lvl)
               && ch_fault_val[5:4] == 2'h0 && ch_fault_val[1:0] == 2'h0;
  endproperty
  a_dc_flags: assert property (p_dc_flags)
    else $error("dc offset flags do not follow detectors");

  property p_clk_flag;
    @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> glb_fault_val[4] == $past(invalid_clock_lvl);
  endproperty
  a_clk_flag: assert property (p_clk_flag)
    else $error("clock fault flag does not follow detector");

  property p_pov_flag;
    @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> glb_fault_val[3] == $past(power_stage_overvoltage_lvl);
  endproperty
  a_pov_flag: assert property (p_pov_flag)
    else $error("power stage overvoltage flag wrong");

  property p_bov_flag;
    @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> glb_fault_val[2] == $past(battery_overvoltage_lvl);
  endproperty
  a_bov_flag: assert property (p_bov_flag)
    else $error("battery overvoltage flag wrong");

  property p_puv_flag;
    @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> glb_fault_val[1] == $past(power_stage_undervoltage_lvl);
  endproperty
  a_puv_flag: assert property (p_puv_flag)
    else $error("power stage undervoltage flag wrong");

  property p_buv_flag;
    @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> glb_fault_val[0] == $past(battery_undervoltage_lvl)
               && glb_fault_val[7:5] == 3'h0;
  endproperty
  a_buv_flag: assert property (p_buv_flag)
    else $error("battery undervoltage flag wrong");

  property p_diag_read;
    @(posedge mclk) disable iff (!reset_n)
      s_rd(ADDR_DIAG_RES) |=> reg_rdata == {$past(res1), $past(res2)};
  endproperty
  a_diag_read: assert property (p_diag_read)
    else $error("diagnostic report read mismatch");

  property p_lo_bits;
    @(posedge mclk) disable iff (!reset_n)
      s_rd(ADDR_LO_RES) |=> reg_rdata[3:2] == $past(lo_found);
  endproperty
  a_lo_bits: assert property (p_lo_bits)
    else $error("line output bits read mismatch");

  property p_rdata_hold;
    @(posedge mclk) disable iff (!reset_n)
      !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  property p_ctrl_write;
    @(posedge mclk) disable iff (!reset_n)
      s_wr(ADDR_STATE_CTRL) |=> st_reg.state_ctrl == $past(reg_wdata);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("state control write not stored");

  property p_thr_keep;
    @(posedge mclk) disable iff (!reset_n)
      !(reg_wr && reg_addr == ADDR_THRESH) |=> $stable(st_reg.thresh);
  endproperty
  a_thr_keep: assert property (p_thr_keep)
    else $error("threshold changed without a write");

  property p_rd_quiet;
    @(posedge mclk) disable iff (!reset_n)
      reg_rd && !reg_wr |=> $stable(st_reg.state_ctrl) && $stable(st_reg.diag_ctrl);
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read disturbed a control register");

  property p_diag_ctrl;
    @(posedge mclk) disable iff (!reset_n)
      s_wr(ADDR_DIAG_CTRL) |=> auto_diag_skip == $past(reg_wdata[SKIP_BIT])
                               && line_out_diag_enable == $past(reg_wdata[LO_EN_BIT]);
  endproperty
  a_diag_ctrl: assert property (p_diag_ctrl)
    else $error("diagnostic control bits not stored");

endmodule // ldfsr_top

/* ldfsr_pkg.sv */
// Purpose: shared constants and types for the load diagnostic and fault register bank
// Assumes: byte-wide register port on the device control interface
// Notes:   channel state codes are fixed by the register encoding

package ldfsr_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_STATE_CTRL = 8'h04;
  localparam logic [7:0] ADDR_DIAG_CTRL  = 8'h09;
  localparam logic [7:0] ADDR_THRESH     = 8'h0a;
  localparam logic [7:0] ADDR_DIAG_RES   = 8'h0c;
  localparam logic [7:0] ADDR_LO_RES     = 8'h0e;
  localparam logic [7:0] ADDR_STATE_RB   = 8'h0f;
  localparam logic [7:0] ADDR_CH_FAULT   = 8'h10;
  localparam logic [7:0] ADDR_GLB_FAULT  = 8'h11;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_STATE_CTRL = 8'h55;
  localparam logic [7:0] RST_DIAG_CTRL  = 8'h00;
  localparam logic [7:0] RST_THRESH     = 8'h11;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [3:0] RST_FLAGS      = 4'h0;
  localparam logic [3:0] STATE_RSVD     = 4'h5;

  // ==========================================================
  // field positions
  localparam int SKIP_BIT    = 0;
  localparam int LO_EN_BIT   = 1;
  localparam int CH1_HI      = 7;
  localparam int CH1_LO      = 4;
  localparam int CH2_HI      = 3;
  localparam int CH2_LO      = 0;
  localparam int ST1_HI      = 7;
  localparam int ST1_LO      = 6;
  localparam int ST2_HI      = 5;
  localparam int ST2_LO      = 4;

  // ==========================================================
  // channel state codes
  typedef enum logic [1:0] {
    CHST_PLAY = 2'h0,
    CHST_HIZ  = 2'h1,
    CHST_MUTE = 2'h2,
    CHST_DIAG = 2'h3
  } ldfsr_chst_t;

endpackage : ldfsr_pkg

/* ldfsr_fault.sv */
// Purpose: registered copy of live fault detector levels
// Assumes: detector levels synchronous to mclk
// Notes:   flags follow the detectors one cycle late

`timescale 1ns/100ps

module ldfsr_fault
  import ldfsr_pkg::*;
#(
  parameter int W = 9
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] fault_lvl,
  output logic      [W-1:0] fault_flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } ldfsr_fault_st_t;

  ldfsr_fault_st_t st_reg;
  ldfsr_fault_st_t st_next;

  if (W < 1) begin : g_chk
    $error("fault width must be positive");
  end

  // ==========================================================
  // capture
  always_comb begin
    st_next       = st_reg;
    st_next.flags = fault_lvl;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_reg.flags <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fault_flags = st_reg.flags;

  property p_fault_track;
    @(posedge mclk) disable iff (!reset_n)
      ##1 fault_flags == $past(fault_lvl);
  endproperty
  a_fault_track: assert property (p_fault_track)
    else $error("fault flag does not follow its detector");

endmodule // ldfsr_fault

/* ldfsr_chan.sv */
// Purpose: one channel state tracker with DC diagnostic trigger and result latch
// Assumes: sequencer pulses diag_done with results valid
// Notes:   host diag request runs once, then the channel rests in diag state

`timescale 1ns/100ps

module ldfsr_chan
  import ldfsr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [1:0]  req_state,
  input  wire logic        auto_diag_skip,
  input  wire logic        line_out_diag_enable,
  input  wire logic        chan_fault,
  input  wire logic        diag_done,
  input  wire logic [3:0]  diag_result,
  input  wire logic        line_out_seen,
  output logic             diag_start,
  output logic [1:0]       state_readback,
  output logic [3:0]       result_flags,
  output logic             line_out_found
);

  typedef struct packed {
    ldfsr_chst_t applied;
    logic        busy;
    logic        fault_q;
    logic [3:0]  flags;
    logic        lo;
  } ldfsr_chan_st_t;

  ldfsr_chan_st_t st_reg;
  ldfsr_chan_st_t st_next;
  logic           leave_hiz;
  logic           fault_rise;
  logic           manual;

  // ==========================================================
  // diagnostic trigger
  assign leave_hiz  = st_reg.applied == CHST_HIZ && req_state != CHST_HIZ
                      && req_state != CHST_DIAG;
  assign fault_rise = chan_fault && !st_reg.fault_q;
  assign manual     = req_state == CHST_DIAG && st_reg.applied != CHST_DIAG;
  assign diag_start = !st_reg.busy
                      && (manual || (!auto_diag_skip && (leave_hiz || fault_rise)));

  always_comb begin
    st_next         = st_reg;
    st_next.fault_q = chan_fault;
    if (st_reg.busy) begin
      if (diag_done) begin
        st_next.busy  = 1'b0;
        st_next.flags = diag_result;
        if (line_out_diag_enable) begin
          st_next.lo = line_out_seen;
        end
        st_next.applied = ldfsr_chst_t'(req_state);
      end
    end else if (diag_start) begin
      st_next.busy = 1'b1;
    end else begin
      st_next.applied = ldfsr_chst_t'(req_state);
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_reg.applied <= CHST_HIZ;
      st_reg.busy    <= 1'b0;
      st_reg.fault_q <= 1'b0;
      st_reg.flags   <= RST_FLAGS;
      st_reg.lo      <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign state_readback = st_reg.busy ? CHST_DIAG : st_reg.applied;
  assign result_flags   = st_reg.flags;
  assign line_out_found = st_reg.lo;

  // ==========================================================
  // checks
  sequence s_leave;
    !st_reg.busy && leave_hiz && !auto_diag_skip;
  endsequence

  property p_auto_start;
    @(posedge mclk) disable iff (!reset_n)
      s_leave |-> diag_start ##1 (st_reg.busy && state_readback == CHST_DIAG);
  endproperty
  a_auto_start: assert property (p_auto_start)
    else $error("no diagnostic after leaving high impedance");

  property p_skip;
    @(posedge mclk) disable iff (!reset_n)
      auto_diag_skip && !manual |-> !diag_start;
  endproperty
  a_skip: assert property (p_skip)
    else $error("automatic diagnostic ran while skipped");

  property p_latch;
    @(posedge mclk) disable iff (!reset_n)
      st_reg.busy && diag_done |=> result_flags == $past(diag_result);
  endproperty
  a_latch: assert property (p_latch)
    else $error("diagnostic result not latched");

  property p_lo_gate;
    @(posedge mclk) disable iff (!reset_n)
      !line_out_diag_enable |=> $stable(line_out_found);
  endproperty
  a_lo_gate: assert property (p_lo_gate)
    else $error("line output flag changed while disabled");

endmodule // ldfsr_chan

/* ldfsr_seq_model.sv */
// Purpose: behavioural diagnostic sequencer facing the register bank
// Assumes: diag_start sampled on mclk rising edge
// Notes:   results are only valid in the done cycle, inverted otherwise

`timescale 1ns/100ps

module ldfsr_seq_model
  import ldfsr_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [1:0] diag_start,
  input  wire logic       slow,
  input  wire logic [3:0] res1_set,
  input  wire logic [3:0] res2_set,
  input  wire logic [1:0] lo_set,
  output logic      [1:0] diag_done,
  output logic      [3:0] res1,
  output logic      [3:0] res2,
  output logic      [1:0] lo_seen
);
  logic [1:0] busy;
  logic [4:0] cnt [2];

  // ==========================================================
  // one run per channel, prompt or slow
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      busy      <= 2'b00;
      diag_done <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        diag_done[i] <= 1'b0;
        if (diag_start[i] && !busy[i]) begin
          busy[i] <= 1'b1;
          cnt[i]  <= slow ? 5'd12 : 5'd2;
        end else if (busy[i]) begin
          if (cnt[i] == 5'd0) begin
            busy[i]      <= 1'b0;
            diag_done[i] <= 1'b1;
          end else begin
            cnt[i] <= cnt[i] - 5'd1;
          end
        end
      end
    end
  end

  // ==========================================================
  // set results only in the done cycle, inverted otherwise
  assign res1    = diag_done[0] ? res1_set : ~res1_set;
  assign res2    = diag_done[1] ? res2_set : ~res2_set;
  assign lo_seen = (|diag_done) ? lo_set : ~lo_set;
endmodule // ldfsr_seq_model

/* testbench.sv */
// Purpose: self-checking bench for the register bank
// Assumes: registered read data, one-cycle strobes
// Notes:   expectations from the register map

`timescale 1ns/100ps

module testbench;
  import ldfsr_pkg::*;

  logic       mclk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] diag_done, line_out_seen, diag_start, oc_lvl = 2'b00, dc_lvl = 2'b00;
  logic [4:0] glb_lvl = 5'h00;
  logic [3:0] r1, r2, th1, th2, res1_set = 4'h0, res2_set = 4'h0;
  logic [1:0] st1, st2, lo_set = 2'b00;
  logic       slow = 1'b0;
  logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h2, 4'h9};
  logic [7:0] ro_addr [5] = '{ADDR_DIAG_RES, ADDR_LO_RES, ADDR_STATE_RB, ADDR_CH_FAULT,
                              ADDR_GLB_FAULT};
  logic [7:0] ro_exp [5] = '{8'h00, 8'h00, 8'h55, 8'h00, 8'h00};
  logic [8:0] v;
  int         failures = 0;
  int         n_checks = 0;
  int         starts [2];
  int         dones [2];

  always #12.5 mclk = ~mclk;

  ldfsr_top dut_u (
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .diag_done(diag_done),
    .first_chan_diag_result(r1), .second_chan_diag_result(r2),
    .line_out_seen(line_out_seen), .overcurrent_lvl(oc_lvl), .dc_offset_lvl(dc_lvl),
    .invalid_clock_lvl(glb_lvl[4]), .power_stage_overvoltage_lvl(glb_lvl[3]),
    .battery_overvoltage_lvl(glb_lvl[2]), .power_stage_undervoltage_lvl(glb_lvl[1]),
    .battery_undervoltage_lvl(glb_lvl[0]), .diag_start(diag_start),
    .first_chan_short_threshold(th1), .second_chan_short_threshold(th2),
    .first_chan_state(st1), .second_chan_state(st2)
  );

  ldfsr_seq_model seq_u (
    .mclk(mclk), .reset_n(reset_n), .diag_start(diag_start), .slow(slow),
    .res1_set(res1_set), .res2_set(res2_set), .lo_set(lo_set), .diag_done(diag_done),
    .res1(r1), .res2(r2), .lo_seen(line_out_seen)
  );

  // ==========================================================
  // run counters
  always @(posedge mclk) begin
    if (reset_n && diag_start[0]) starts[0]++;
    if (reset_n && diag_start[1]) starts[1]++;
    if (reset_n && diag_done[0]) dones[0]++;
    if (reset_n && diag_done[1]) dones[1]++;
  end

  // ==========================================================
  // access tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk(reg_rdata, e, "register read");
  endtask

  task automatic wait_done(input int ch, input int target);
    for (int i = 0; i < 60 && dones[ch] < target; i++) @(posedge mclk);
    chk(8'(dones[ch] == target), 8'h01, "diag run count");
  endtask

  task automatic end_sim;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    failures++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_sim();
  end

  // ==========================================================
  // test sequence
  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) rd(ro_addr[i], ro_exp[i]);
    rd(ADDR_THRESH, RST_THRESH);
    rd(8'h20, 8'h00);
    chk({th1, th2}, 8'h11, "threshold ports");
    chk({st1, st2, 4'h5}, 8'h55, "state ports");
    $display("test reset values done");

    for (int i = 0; i < 4; i++) begin
      wr(ADDR_THRESH, {codes[i], codes[(i + 1) % 4]});
      rd(ADDR_THRESH, {codes[i], codes[(i + 1) % 4]});
      chk({th1, th2}, {codes[i], codes[(i + 1) % 4]}, "threshold ports");
    end
    for (int i = 0; i < 5; i++) wr(ro_addr[i], 8'hff);
    for (int i = 0; i < 5; i++) rd(ro_addr[i], ro_exp[i]);
    $display("test threshold and read-only done");

    wr(ADDR_DIAG_CTRL, 8'h02);
    slow     <= 1'b1;
    res1_set <= 4'ha;
    res2_set <= 4'h5;
    lo_set   <= 2'b10;
    wr(ADDR_STATE_CTRL, 8'h25);
    repeat (2) @(posedge mclk);
    rd(ADDR_STATE_RB, 8'hf5);
    wait_done(0, 1);
    wait_done(1, 1);
    rd(ADDR_DIAG_RES, 8'ha5);
    rd(ADDR_LO_RES, 8'h08);
    rd(ADDR_STATE_RB, 8'h25);
    $display("test auto diagnostics done");

    wr(ADDR_DIAG_CTRL, 8'h00);
    slow     <= 1'b0;
    res1_set <= 4'h1;
    res2_set <= 4'h8;
    lo_set   <= 2'b01;
    wr(ADDR_STATE_CTRL, 8'he5);
    wait_done(0, 2);
    rd(ADDR_DIAG_RES, 8'h15);
    rd(ADDR_LO_RES, 8'h08);
    rd(ADDR_STATE_RB, 8'he5);
    chk(8'(dones[1]), 8'h01, "second channel idle");
    $display("test manual diagnostics done");

    oc_lvl <= 2'b01;
    wait_done(1, 2);
    rd(ADDR_DIAG_RES, 8'h18);
    rd(ADDR_CH_FAULT, 8'h40);
    oc_lvl <= 2'b00;
    repeat (3) @(posedge mclk);
    wr(ADDR_DIAG_CTRL, 8'h01);
    dc_lvl <= 2'b01;
    repeat (20) @(posedge mclk);
    chk(8'(starts[1]), 8'h02, "skip blocks auto run");
    rd(ADDR_CH_FAULT, 8'h04);
    $display("test fault diagnostics done");

    for (int i = 0; i < 9; i++) begin
      v = 9'h001 << i;
      @(posedge mclk);
      oc_lvl  <= v[8:7];
      dc_lvl  <= v[6:5];
      glb_lvl <= v[4:0];
      repeat (2) @(posedge mclk);
      rd(ADDR_CH_FAULT, {v[8:7], 2'b00, v[6:5], 2'b00});
      rd(ADDR_GLB_FAULT, {3'b000, v[4:0]});
    end
    $display("test fault flags done");
    end_sim();
  end
endmodule // testbench
